// ---- rtl/stc_pkg.sv ----
package stc_pkg;
   // Register byte offsets
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_STB = 8'h04;
   localparam logic [7:0] A_REPLY = 8'h08;
   localparam logic [7:0] A_SRE = 8'h0C;
   localparam logic [7:0] A_EN0 = 8'h10;
   localparam logic [7:0] A_EV0 = 8'h20;
   localparam logic [7:0] A_TRIGLEN = 8'h30;
   localparam logic [7:0] A_ANALOG = 8'h34;
   localparam logic [7:0] A_CDYN = 8'h38;
   localparam logic [7:0] A_CAL = 8'h3C;
   localparam logic [7:0] A_ERR = 8'h40;
   // Command opcodes in CMD[3:0]
   localparam logic [3:0] OP_STBQ = 4'h1;
   localparam logic [3:0] OP_SPOLL = 4'h2;
   localparam logic [3:0] OP_CLS = 4'h3;
   localparam logic [3:0] OP_TRG = 4'h4;
   localparam logic [3:0] OP_TST = 4'h5;
   localparam logic [3:0] OP_WAI = 4'h6;
   localparam logic [3:0] OP_ADJ_STEP = 4'h7;
   localparam logic [3:0] OP_ADJ_VAL = 4'h8;
   localparam logic [3:0] OP_ADJ_EXIT = 4'h9;
   // Event register index (0 standard, 1..3 A..C)
   localparam int EV_STD = 0;
   localparam int EV_C = 3;
   // Status byte positions
   localparam int STB_MAV = 4;
   localparam int STB_RQS = 6;
   // Standard event bits
   localparam int ESR_EXE = 4;
   localparam int ESR_CME = 5;
   // Event register C: self-test failure bit
   localparam int ERC_SELFTEST_FAIL_FLAG = 0;
   // Error numbers
   localparam logic [7:0] ERR_NOT_CAL = 8'h5B;
   localparam logic [7:0] ERR_CAL_INT = 8'h42;
   // External input switching modes
   localparam logic [1:0] AIN_OFF = 2'h0;
   localparam logic [1:0] AIN_ON = 2'h1;
   localparam logic [1:0] AIN_SEQ = 2'h2;
   // Calibration operating points
   localparam logic [1:0] PT_NONE = 2'h0;
   localparam logic [1:0] PT_OFFSET = 2'h1;
   localparam logic [1:0] PT_FULL = 2'h2;
   localparam logic [15:0] CAL_DEFAULT = 16'h8000;
   // AXI responses
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic {CAL_IDLE, CAL_WAIT} stc_cal_t;
endpackage

// ---- rtl/stc_status_trig_adj.sv ----
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module stc_status_trig_adj (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] ev_std_set,
   input wire logic [7:0] ev_a_set,
   input wire logic [7:0] ev_b_set,
   input wire logic [7:0] ev_c_set,
   input wire logic obuf_pending,
   input wire logic pset_active,
   input wire logic sequence_function_parameter,
   input wire logic [15:0] clock_date,
   input wire logic nv_cal_valid,
   input wire logic [15:0] nv_cal_date,
   input wire logic [3:0][15:0] nv_cal_param,
   output logic srq_r,
   output logic trig_exec_r,
   output logic [1:0] cal_point_r,
   output logic [1:0] cal_quantity_r,
   output logic [3:0][15:0] cal_param_r,
   output logic [15:0] cal_date_r,
   output logic nv_store_r,
   output logic uncalibrated_indication,
   output logic uext_en_r,
   output logic iext_en_r,
   output logic current_regulator_dynamics
);
   import stc_pkg::*;

   logic aw_rdy_r, b_vld_r, ar_rdy_r, r_vld_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic [7:0] ev_r [4];
   logic [7:0] en_r [4];
   logic [7:0] ev_set [4];
   logic [7:0] sre_r, reply_r, trig_len_r, err0_r, err1_r;
   logic reply_vld_r, rqs_r, mss_q_r, cal_valid_r, restore_r;
   logic [1:0] u_mode_r, i_mode_r, cal_next_r;
   logic sequence_controlled_switch_r;
   logic [3:0][15:0] cal_new_r;
   stc_cal_t cal_st_r;
   logic wr_hs, rd_hs, cmd_we, mav, mss, seq_on, cal_ok;
   logic [3:0] op;
   logic [1:0] arg_step;
   logic [7:0] stb;
   logic [3:0] sum;
   logic [31:0] rd_val;
   logic rd_err;

   assign s_axi_awready = aw_rdy_r;
   assign s_axi_wready = aw_rdy_r;
   assign s_axi_bvalid = b_vld_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = ar_rdy_r;
   assign s_axi_rvalid = r_vld_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Bus handshakes and command decode
   assign wr_hs = aw_rdy_r & s_axi_awvalid & s_axi_wvalid;
   assign rd_hs = ar_rdy_r & s_axi_arvalid;
   assign cmd_we = wr_hs & s_axi_wstrb[0] & (s_axi_awaddr == A_CMD);
   assign op = cmd_we ? s_axi_wdata[3:0] : 4'h0;
   assign arg_step = s_axi_wdata[5:4];
   assign ev_set[0] = ev_std_set;
   assign ev_set[1] = ev_a_set;
   assign ev_set[2] = ev_b_set;
   assign ev_set[3] = ev_c_set;

   // Status byte assembly
   assign mav = reply_vld_r | obuf_pending;
   assign sum[0] = |(ev_r[EV_STD] & en_r[EV_STD]);
   assign sum[1] = |(ev_r[1] & en_r[1]);
   assign sum[2] = |(ev_r[2] & en_r[2]);
   assign sum[3] = |(ev_r[EV_C] & en_r[EV_C]);
   assign stb[5:0] = {sum[0], mav, sum[3], sum[2], sum[1], 1'b0};
   assign mss = |(stb[5:0] & sre_r[5:0]);
   assign stb[7:6] = {1'b0, mss};

   // Calibration value is good when nonzero
   assign cal_ok = (s_axi_wdata[31:16] != 16'h0000);
   // Sequence source: function parameter or switch command
   assign seq_on = sequence_function_parameter |
                   sequence_controlled_switch_r;

   // Write channel: both address and data taken together
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aw_rdy_r <= 1'b0;
         b_vld_r <= 1'b0;
         bresp_r <= RESP_OK;
      end else begin
         aw_rdy_r <= s_axi_awvalid & s_axi_wvalid & ~aw_rdy_r & ~b_vld_r;
         if (wr_hs) begin
            b_vld_r <= 1'b1;
            bresp_r <= (s_axi_awaddr > A_ERR || s_axi_awaddr[1:0] != 2'h0)
                       ? RESP_SLVERR : RESP_OK;
         end else if (s_axi_bready) begin
            b_vld_r <= 1'b0;
         end
      end
   end

   // Read decode
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_err = 1'b0;
      if (s_axi_araddr == A_STB) begin
         rd_val[7:0] = stb;
      end else if (s_axi_araddr == A_REPLY) begin
         rd_val[8:0] = {reply_vld_r, reply_r};
      end else if (s_axi_araddr == A_SRE) begin
         rd_val[7:0] = sre_r;
      end else if (s_axi_araddr[7:4] == A_EN0[7:4] &&
                   s_axi_araddr[1:0] == 2'h0) begin
         rd_val[7:0] = en_r[s_axi_araddr[3:2]];
      end else if (s_axi_araddr[7:4] == A_EV0[7:4] &&
                   s_axi_araddr[1:0] == 2'h0) begin
         rd_val[7:0] = ev_r[s_axi_araddr[3:2]];
      end else if (s_axi_araddr == A_TRIGLEN) begin
         rd_val[7:0] = trig_len_r;
      end else if (s_axi_araddr == A_ANALOG) begin
         rd_val[9:0] = {iext_en_r, uext_en_r, 3'h0,
                        sequence_controlled_switch_r,
                        i_mode_r, u_mode_r};
      end else if (s_axi_araddr == A_CDYN) begin
         rd_val[0] = current_regulator_dynamics;
      end else if (s_axi_araddr == A_CAL) begin
         rd_val = {cal_date_r, 11'h000, cal_st_r == CAL_WAIT,
                   cal_next_r, 1'b0, cal_valid_r};
      end else if (s_axi_araddr == A_ERR) begin
         rd_val[15:0] = {err1_r, err0_r};
      end else if (s_axi_araddr != A_CMD) begin
         rd_err = 1'b1;
      end
   end

   // Read channel
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ar_rdy_r <= 1'b0;
         r_vld_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OK;
      end else begin
         ar_rdy_r <= s_axi_arvalid & ~ar_rdy_r & ~r_vld_r;
         if (rd_hs) begin
            r_vld_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= rd_err ? RESP_SLVERR : RESP_OK;
         end else if (s_axi_rready) begin
            r_vld_r <= 1'b0;
         end
      end
   end

   // Event registers: set wins over read clear and clear-status
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ev
         logic [7:0] own_set;
         logic clr;
         always_comb begin
            own_set = ev_set[gi];
            if (gi == EV_STD) begin
               own_set[ESR_EXE] = ev_set[gi][ESR_EXE] |
                  (op == OP_TRG && trig_len_r == 8'h00);
               own_set[ESR_CME] = ev_set[gi][ESR_CME] |
                  (op == OP_ADJ_STEP && (cal_st_r != CAL_IDLE ||
                   arg_step != cal_next_r)) |
                  (op == OP_ADJ_VAL && (cal_st_r != CAL_WAIT ||
                   arg_step != cal_next_r));
            end
            if (gi == EV_C) begin
               own_set[ERC_SELFTEST_FAIL_FLAG] =
                  ev_set[gi][ERC_SELFTEST_FAIL_FLAG] |
                  (op == OP_TST && !cal_valid_r);
            end
         end
         assign clr = (op == OP_CLS) ||
            (rd_hs && s_axi_araddr == A_EV0 + 8'(4 * gi));
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               ev_r[gi] <= 8'h00;
            end else begin
               ev_r[gi] <= (clr ? 8'h00 : ev_r[gi]) | own_set;
            end
         end
         // Enable registers written over the bus
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               en_r[gi] <= 8'h00;
            end else if (wr_hs && s_axi_wstrb[0] &&
                         s_axi_awaddr == A_EN0 + 8'(4 * gi)) begin
               en_r[gi] <= s_axi_wdata[7:0];
            end
         end
      end
   endgenerate

   // Service request: set on MSS rise, cleared by poll or clear-status
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rqs_r <= 1'b0;
         mss_q_r <= 1'b0;
         srq_r <= 1'b0;
      end else begin
         mss_q_r <= mss;
         if (mss && !mss_q_r) begin
            rqs_r <= 1'b1;
         end else if (op == OP_SPOLL || op == OP_CLS) begin
            rqs_r <= 1'b0;
         end
         srq_r <= rqs_r;
      end
   end

   // Reply word; a bus read of it empties it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reply_r <= 8'h00;
         reply_vld_r <= 1'b0;
      end else if (op == OP_STBQ) begin
         reply_r <= {1'b0, mss, stb[5], 1'b1, stb[3:0]};
         reply_vld_r <= 1'b1;
      end else if (op == OP_SPOLL) begin
         reply_r <= {1'b0, rqs_r, stb[5:0]};
         reply_vld_r <= 1'b1;
      end else if (op == OP_TST) begin
         reply_r <= {7'h00, ~cal_valid_r};
         reply_vld_r <= 1'b1;
      end else if (rd_hs && s_axi_araddr == A_REPLY) begin
         reply_vld_r <= 1'b0;
      end
   end

   // Error list, newest first
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         err0_r <= 8'h00;
         err1_r <= 8'h00;
      end else if (op == OP_TST && !cal_valid_r) begin
         err0_r <= ERR_CAL_INT;
         err1_r <= ERR_NOT_CAL;
      end else if ((op == OP_ADJ_EXIT && cal_st_r == CAL_WAIT) ||
                   (op == OP_ADJ_VAL && cal_st_r == CAL_WAIT &&
                    arg_step == cal_next_r && !cal_ok)) begin
         err0_r <= ERR_NOT_CAL;
         err1_r <= err0_r;
      end else if (op == OP_CLS) begin
         err0_r <= 8'h00;
         err1_r <= 8'h00;
      end
   end

   // Trigger: pulse the stored list runner when the list length is nonzero, list length untouched
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         trig_exec_r <= 1'b0;
         trig_len_r <= 8'h00;
      end else begin
         trig_exec_r <= (op == OP_TRG) && trig_len_r != 8'h00;
         if (wr_hs && s_axi_wstrb[0] && s_axi_awaddr == A_TRIGLEN) begin
            trig_len_r <= s_axi_wdata[7:0];
         end
      end
   end

   // Configuration registers; wait-to-continue needs no logic
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sre_r <= 8'h00;
         u_mode_r <= AIN_OFF;
         i_mode_r <= AIN_OFF;
         sequence_controlled_switch_r <= 1'b0;
         current_regulator_dynamics <= 1'b0;
      end else if (wr_hs && s_axi_wstrb[0]) begin
         if (s_axi_awaddr == A_SRE) begin
            sre_r <= s_axi_wdata[7:0];
         end else if (s_axi_awaddr == A_ANALOG) begin
            u_mode_r <= s_axi_wdata[1:0];
            i_mode_r <= s_axi_wdata[3:2];
            sequence_controlled_switch_r <= s_axi_wdata[4];
         end else if (s_axi_awaddr == A_CDYN) begin
            current_regulator_dynamics <= s_axi_wdata[0];
         end
      end
   end

   // External control input switching
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         uext_en_r <= 1'b0;
         iext_en_r <= 1'b0;
      end else begin
         uext_en_r <= !pset_active && (u_mode_r == AIN_ON ||
                      (u_mode_r == AIN_SEQ && seq_on));
         iext_en_r <= !pset_active && (i_mode_r == AIN_ON ||
                      (i_mode_r == AIN_SEQ && seq_on));
      end
   end

   // Calibration sequence and power-on restore
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cal_st_r <= CAL_IDLE;
         cal_next_r <= 2'h0;
         cal_point_r <= PT_NONE;
         cal_quantity_r <= 2'h0;
         cal_new_r <= '0;
         cal_param_r <= {4{CAL_DEFAULT}};
         cal_date_r <= 16'h0000;
         cal_valid_r <= 1'b0;
         uncalibrated_indication <= 1'b1;
         restore_r <= 1'b1;
         nv_store_r <= 1'b0;
      end else begin
         nv_store_r <= 1'b0;
         if (restore_r) begin
            restore_r <= 1'b0;
            cal_valid_r <= nv_cal_valid;
            uncalibrated_indication <= ~nv_cal_valid;
            cal_date_r <= nv_cal_date;
            cal_param_r <= nv_cal_valid ? nv_cal_param
                                        : {4{CAL_DEFAULT}};
         end else if (op == OP_ADJ_EXIT && cal_st_r == CAL_WAIT) begin
            cal_st_r <= CAL_IDLE;
            cal_next_r <= 2'h0;
            cal_point_r <= PT_NONE;
            cal_valid_r <= 1'b0;
            uncalibrated_indication <= 1'b1;
            cal_param_r <= {4{CAL_DEFAULT}};
         end else if (op == OP_ADJ_STEP && cal_st_r == CAL_IDLE &&
                      arg_step == cal_next_r) begin
            cal_st_r <= CAL_WAIT;
            cal_quantity_r <= arg_step;
            cal_point_r <= arg_step[0] ? PT_FULL : PT_OFFSET;
         end else if (op == OP_ADJ_VAL && cal_st_r == CAL_WAIT &&
                      arg_step == cal_next_r) begin
            cal_st_r <= CAL_IDLE;
            cal_point_r <= PT_NONE;
            if (!cal_ok) begin
               cal_next_r <= 2'h0;
               cal_valid_r <= 1'b0;
               uncalibrated_indication <= 1'b1;
               cal_param_r <= {4{CAL_DEFAULT}};
            end else if (cal_next_r == 2'h3) begin
               cal_next_r <= 2'h0;
               cal_param_r <= {s_axi_wdata[31:16], cal_new_r[2:0]};
               cal_date_r <= clock_date;
               cal_valid_r <= 1'b1;
               uncalibrated_indication <= 1'b0;
               nv_store_r <= 1'b1;
            end else begin
               cal_new_r[cal_next_r] <= s_axi_wdata[31:16];
               cal_next_r <= cal_next_r + 2'h1;
            end
         end
      end
   end

   a_stb_query_mav: assert property (@(posedge clk_sys) disable iff (!rst_n)
      op == OP_STBQ |=> reply_vld_r && reply_r[STB_MAV] && !reply_r[7])
      else $error("status reply lacks MAV");
   a_poll_rqs_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      op == OP_SPOLL && !(mss && !mss_q_r) |=> !rqs_r
      && reply_r[STB_RQS] == $past(rqs_r))
      else $error("poll RQS wrong");
   a_mss_summary: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (mss && !mss_q_r) |=> rqs_r)
      else $error("MSS did not raise request");
   a_trig_empty: assert property (@(posedge clk_sys) disable iff (!rst_n)
      op == OP_TRG && trig_len_r == 8'h00 |=> ev_r[EV_STD][ESR_EXE]
      && !trig_exec_r)
      else $error("empty trigger not flagged");
   a_trig_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
      op == OP_TRG |=> $stable(trig_len_r))
      else $error("trigger changed list");
   a_tst_fail: assert property (@(posedge clk_sys) disable iff (!rst_n)
      op == OP_TST && !cal_valid_r |=> reply_r == 8'h01
      && ev_r[EV_C][ERC_SELFTEST_FAIL_FLAG] && err1_r == ERR_NOT_CAL)
      else $error("self-test failure not reported");
   a_exit_uncalibrated_indication: assert property (@(posedge clk_sys) disable iff (!rst_n)
      op == OP_ADJ_EXIT && cal_st_r == CAL_WAIT && !restore_r |=>
      uncalibrated_indication && cal_param_r[0] == CAL_DEFAULT)
      else $error("exit left calibration valid");
   a_pset_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pset_active |=> !uext_en_r && !iext_en_r)
      else $error("external input active with power setpoint");
   a_cls_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      op == OP_CLS && ev_std_set == 8'h00 |=> ev_r[EV_STD] == 8'h00
      && err0_r == 8'h00)
      else $error("clear-status left events");
endmodule

// ---- verif/stc_host_model.sv ----
`timescale 1ns/1ns
// Host side: AXI4-Lite master, one access at a time
module stc_host_model (
   input wire logic clk_sys,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [1:0] s_axi_bresp,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready,
   output logic hang
);
   // Response code of the last write
   logic [1:0] last_bresp;
   // Idle bus from time zero
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, hang} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
   end
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      last_bresp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 40) hang <= 1'b1;
   endtask
   // Read: address held until taken, data taken with rvalid
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      int n;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 40) hang <= 1'b1;
   endtask
endmodule

// ---- verif/stc_status_trig_adj_tb.sv ----
`timescale 1ns/1ns
// Bench: host model drives the bus, results go through chk
module stc_status_trig_adj_tb;
   import stc_pkg::*;
   logic clk_sys, rst_n, obuf_pending, pset_active, nv_cal_valid, hang;
   logic sequence_function_parameter, srq_r, trig_exec_r, nv_store_r;
   logic uncalibrated_indication, uext_en_r, iext_en_r;
   logic current_regulator_dynamics, s_axi_awvalid, s_axi_awready;
   logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] ev_a_set, s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_rresp, s_axi_bresp, cal_point_r, cal_quantity_r;
   logic [3:0][15:0] cal_param_r;
   logic [15:0] cal_date_r, clock_date;
   int n_mismatch, n_tests, n_trig, n_store;
   stc_status_trig_adj i_stc_status_trig_adj (
      .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .ev_std_set(8'h00), .ev_a_set,
      .ev_b_set(8'h00), .ev_c_set(8'h00), .obuf_pending, .pset_active,
      .sequence_function_parameter, .clock_date, .nv_cal_valid,
      .nv_cal_date(16'h0707), .nv_cal_param({4{16'h1111}}), .srq_r,
      .trig_exec_r, .cal_point_r, .cal_quantity_r, .cal_param_r,
      .cal_date_r, .nv_store_r, .uncalibrated_indication, .uext_en_r,
      .iext_en_r, .current_regulator_dynamics);
   stc_host_model i_stc_host_model (
      .clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .hang);
   // 50 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Pulse counters; a stuck bus ends the run
   always @(negedge clk_sys) begin
      if (trig_exec_r === 1'b1) n_trig++;
      if (nv_store_r === 1'b1) n_store++;
   end
   always @(posedge hang) begin
      n_mismatch++;
      tally_and_finish();
   end
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(logic [7:0] a, logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      i_stc_host_model.rd(a, d, r);
      chk($sformatf("reg %h", a), e, d);
   endtask
   task automatic w(logic [7:0] a, logic [31:0] d);
      i_stc_host_model.wr(a, d);
   endtask
   task automatic rst();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
   endtask
   // Summaries, buffer flag, service request, poll, clear, query
   task automatic t_status();
      w(A_EN0 + 8'h04, 32'h01);
      ev_a_set <= 8'h01;
      @(posedge clk_sys);
      ev_a_set <= 8'h00;
      obuf_pending <= 1'b1;
      rchk(A_STB, 32'h12);
      w(A_SRE, 32'h02);
      rchk(A_STB, 32'h52);
      chk("srq", 1, srq_r);
      w(A_CMD, OP_SPOLL);
      rchk(A_REPLY, 32'h152);
      chk("srq", 0, srq_r);
      w(A_CMD, OP_CLS);
      rchk(A_STB, 32'h10);
      obuf_pending <= 1'b0;
      w(A_CMD, OP_STBQ);
      rchk(A_REPLY, 32'h110);
      rchk(A_STB, 32'h00);
   endtask
   // Trigger with empty and filled list, then wait-to-continue
   task automatic t_trig();
      w(A_TRIGLEN, 32'h0);
      w(A_CMD, OP_TRG);
      rchk(A_EV0, 32'h10);
      rchk(A_EV0, 32'h00);
      w(A_TRIGLEN, 32'h03); // List holds no trigger command
      w(A_CMD, OP_TRG);
      repeat (2) @(posedge clk_sys);
      chk("trig", 1, n_trig);
      rchk(A_TRIGLEN, 32'h03);
      w(A_CMD, OP_WAI);
      rchk(A_EV0, 32'h00);
   endtask
   // Self-test, wrong step, four steps in order, then abort
   task automatic t_cal();
      int s;
      w(A_CMD, OP_TST);
      rchk(A_REPLY, 32'h101);
      rchk(A_EV0 + 8'h0C, 32'h01);
      rchk(A_ERR, 32'h5B42);
      w(A_CMD, {26'h0, 2'd1, OP_ADJ_STEP});
      rchk(A_EV0, 32'h20);
      chk("point", PT_NONE, cal_point_r);
      clock_date <= 16'h2468;
      for (s = 0; s < 4; s++) begin // Fixed step order
         w(A_CMD, {26'h0, s[1:0], OP_ADJ_STEP});
         chk("point", s[0] ? PT_FULL : PT_OFFSET, cal_point_r);
         chk("step", s, cal_quantity_r);
         w(A_CMD, {16'h1000 + s[15:0], 10'h0, s[1:0], OP_ADJ_VAL});
      end
      chk("store", 1, n_store);
      chk("date", 16'h2468, cal_date_r);
      chk("param", 16'h1003, cal_param_r[3]);
      w(A_CMD, OP_TST);
      rchk(A_REPLY, 32'h100);
      w(A_CMD, OP_ADJ_STEP);
      w(A_CMD, OP_ADJ_EXIT);
      chk("uncalibrated_indication", 1, uncalibrated_indication);
      chk("param", CAL_DEFAULT, cal_param_r[0]);
      w(A_CMD, OP_TST);
      rchk(A_REPLY, 32'h101);
      // Zero measured value fails the step
      w(A_CMD, {26'h0, 2'd0, OP_ADJ_STEP});
      w(A_CMD, {26'h0, 2'd0, OP_ADJ_VAL});
      rchk(A_CAL, 32'h2468_0000);
      rchk(A_ERR, 32'h425B);
   endtask
   // Input modes, lockout, dynamics, unmapped read, power-on restore
   task automatic t_misc();
      logic [31:0] d;
      logic [1:0] r;
      w(A_ANALOG, 32'h09);
      rchk(A_ANALOG, 32'h109);
      sequence_function_parameter <= 1'b1;
      rchk(A_ANALOG, 32'h309);
      chk("iext", 1, iext_en_r);
      pset_active <= 1'b1;
      rchk(A_ANALOG, 32'h009);
      chk("uext", 0, uext_en_r);
      w(A_CDYN, 32'h1);
      chk("bresp", RESP_OK, i_stc_host_model.last_bresp);
      chk("dyn", 1, current_regulator_dynamics);
      rchk(A_CDYN, 32'h1);
      i_stc_host_model.rd(8'h44, d, r);
      chk("resp", RESP_SLVERR, r);
      w(8'h44, 32'h0);
      chk("bresp", RESP_SLVERR, i_stc_host_model.last_bresp);
      nv_cal_valid <= 1'b1;
      rst();
      chk("date", 16'h0707, cal_date_r);
      chk("param", 16'h1111, cal_param_r[2]);
      w(A_CMD, OP_TST);
      rchk(A_REPLY, 32'h100);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      {rst_n, obuf_pending, pset_active, nv_cal_valid} = '0;
      sequence_function_parameter = 1'b0;
      ev_a_set = 8'h00;
      clock_date = 16'h0;
      rst();
      t_status();
      t_trig();
      t_cal();
      t_misc();
      tally_and_finish();
   end
endmodule
